// [hw/bcx_regs.vh]
`ifndef BCX_REGS_VH
`define BCX_REGS_VH
// Register port indices.
`define BCX_REG_CTRL   4'h0
`define BCX_REG_LOG    4'h6
`define BCX_REG_HPEN   4'h7
`define BCX_REG_HPST   4'h8
`define BCX_REG_STDEN  4'h9
`define BCX_REG_POLL   4'ha
`define BCX_REG_CUR    4'hb
// Control register fields.
`define BCX_CR_START   0
`define BCX_CR_RTRY    1
`define BCX_CR_BUSY    15
`define BCX_CR_HOLD    14
// Command block word offsets.
`define BCX_CB_CTRL    16'h0001
`define BCX_CB_CMD1    16'h0002
`define BCX_CB_DPTR    16'h0004
`define BCX_CB_STAT1   16'h0005
`define BCX_CB_TAIL    16'h0007
// Log entry word offsets.
`define BCX_LG_ISW     16'h0000
`define BCX_LG_PTR     16'h0001
`define BCX_LG_TAIL    16'h0002
// Control word bits, and the TR bit of the command word.
`define BCX_CW_MERR    15
`define BCX_CW_SKIP    14
`define BCX_CW_IC      13
`define BCX_CW_POLL    12
`define BCX_CW_RETRY   11
`define BCX_CW_LAST    10
`define BCX_CW_RTRT    9
`define BCX_CMD_TR     10
// Interrupt status word bits.
`define BCX_IS_ACC     15
`define BCX_IS_POLL    3
`define BCX_IS_RFAIL   2
`define BCX_IS_MERR    1
`define BCX_IS_IC      0
// High-priority status and enable bits.
`define BCX_HP_LAST    0
`define BCX_HP_MERR    1
`define BCX_HP_STD     2
// Reset values.
`define BCX_RST_W16    16'h0000
// Timing.
`define BCX_CLK_NS     20
`define BCX_STEP_NS    16000
`define BCX_STEP_CYC   (`BCX_STEP_NS / `BCX_CLK_NS)
`endif

// [hw/bcx_exception_log.v]
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "bcx_regs.vh"
`default_nettype none

module bcx_exception_log (
    input  wire        I_CLK,
    input  wire        I_RESET,
    input  wire [3:0]  I_REG_ADDR,
    input  wire [15:0] I_REG_WDATA,
    input  wire        I_REG_WR,
    input  wire        I_REG_RD,
    output reg  [15:0] O_REG_RDATA,
    output reg         O_DMA_REQ,
    input  wire        I_DMA_GNT,
    output reg  [15:0] O_MEM_ADDR,
    output reg  [15:0] O_MEM_WDATA,
    output reg         O_MEM_RD,
    output reg         O_MEM_WR,
    input  wire        I_MEM_ACK,
    input  wire [15:0] I_MEM_RDATA,
    output reg         O_MSG_START,
    output reg  [15:0] O_MSG_CMD,
    output reg         O_MSG_ALT_BUS,
    input  wire        I_MSG_DONE,
    input  wire [15:0] I_MSG_STATUS,
    input  wire        I_MSG_ERROR,
    output reg  [15:0] O_TX_DATA,
    output reg         O_TX_VALID,
    input  wire        I_TX_TAKE,
    output reg         O_HIGH_PRIORITY_IRQ_N,
    output reg         O_STANDARD_IRQ_LEVEL_N,
    output reg         O_STANDARD_IRQ_PULSE_N,
    output wire        O_BUSY
);

    //--------------------------------------------------------------
    // States
    //--------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_FCTRL = 4'h1;
    localparam [3:0] S_FCMD  = 4'h2;
    localparam [3:0] S_FDPTR = 4'h3;
    localparam [3:0] S_FDATA = 4'h4;
    localparam [3:0] S_RUN   = 4'h5;
    localparam [3:0] S_WSTAT = 4'h6;
    localparam [3:0] S_LISW  = 4'h7;
    localparam [3:0] S_LPTR  = 4'h8;
    localparam [3:0] S_LTAIL = 4'h9;
    localparam [3:0] S_HOLD  = 4'ha;
    localparam [3:0] S_DELAY = 4'hb;
    localparam [3:0] S_WCTRL = 4'hc;
    localparam [3:0] S_RTAIL = 4'hd;
    localparam [3:0] S_DHOLD = 4'he;

    localparam integer STEP_INT = `BCX_STEP_CYC;
    localparam [9:0]   STEP_CYC = STEP_INT[9:0];

    reg  [3:0]  st_r;
    reg  [3:0]  st_nxt;
    reg  [15:0] log_r;
    reg  [15:0] cur_r;
    reg  [15:0] blk_r;
    reg  [15:0] ctrl_r;
    reg  [15:0] dptr_r;
    reg  [15:0] idx_r;
    reg  [15:0] stat_r;
    reg  [15:0] isw_r;
    reg  [15:0] poll_r;
    reg  [2:0]  hpen_r;
    reg  [2:0]  hpst_r;
    reg  [2:0]  hpst_nxt;
    reg  [2:0]  hpst_set;
    reg  [3:0]  stden_r;
    reg  [2:0]  gcfg_r;
    reg  [1:0]  rcnt_r;
    reg         first_r;
    reg         err_blk_r;
    reg         retry_r;
    reg         hold_r;
    reg         skip_r;
    reg         need_tx_r;
    reg  [9:0]  presc_r;
    reg  [7:0]  ticks_r;
    reg  [15:0] rdat_nxt;
    reg  [3:0]  cont_st;

    wire        xfer    = I_DMA_GNT & I_MEM_ACK;
    wire        start   = I_REG_WR & (I_REG_ADDR == `BCX_REG_CTRL)
                          & I_REG_WDATA[`BCX_CR_START] & (st_r == S_IDLE);
    wire        last_blk = ctrl_r[`BCX_CW_LAST];
    wire        err_now = I_MSG_ERROR | I_MSG_STATUS[`BCX_CW_MERR];
    wire        poll_hit = ctrl_r[`BCX_CW_POLL] & (|(I_MSG_STATUS & poll_r));
    wire        rtry_ok = err_now & ctrl_r[`BCX_CW_RETRY] & gcfg_r[0];
    wire        fetch   = (st_r == S_RUN) & need_tx_r & ~O_TX_VALID;
    wire [15:0] raw_ev;

    assign O_BUSY = (st_r != S_IDLE);

    // Event bits are set to one when the condition occurred.
    assign raw_ev = {12'h000,
                     poll_hit,
                     rtry_ok & (rcnt_r == 2'b00),
                     err_now,
                     ctrl_r[`BCX_CW_IC]};

    //--------------------------------------------------------------
    // Sequencing
    //--------------------------------------------------------------
    // Shared exit after the log and hold steps; a pending retry keeps the
    // block, and the end of the list beats both.
    always @* begin
        if (last_blk) begin
            cont_st = S_IDLE;
        end else if (retry_r) begin
            cont_st = S_FCTRL;
        end else begin
            cont_st = S_DELAY;
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (start) begin
                    st_nxt = S_FCTRL;
                end
            end
            S_FCTRL: begin
                if (xfer) begin
                    st_nxt = S_FCMD;
                end
            end
            S_FCMD: begin
                if (xfer) begin
                    st_nxt = S_FDPTR;
                end
            end
            S_FDPTR: begin
                if (xfer) begin
                    if (ctrl_r[`BCX_CW_SKIP]) begin
                        st_nxt = (|(raw_ev[0] & stden_r[0])) ? S_LISW : cont_st;
                    end else if (~O_MSG_CMD[`BCX_CMD_TR] & ~ctrl_r[`BCX_CW_RTRT]) begin
                        st_nxt = S_FDATA;
                    end else begin
                        st_nxt = S_RUN;
                    end
                end
            end
            S_FDATA: begin
                if (xfer) begin
                    st_nxt = S_RUN;
                end
            end
            S_RUN: begin
                if (I_MSG_DONE) begin
                    st_nxt = S_WSTAT;
                end
            end
            S_WSTAT: begin
                if (xfer) begin
                    if (|isw_r) begin
                        st_nxt = S_LISW;
                    end else if (hold_r) begin
                        st_nxt = S_HOLD;
                    end else begin
                        st_nxt = cont_st;
                    end
                end
            end
            S_LISW: begin
                if (xfer) begin
                    st_nxt = S_LPTR;
                end
            end
            S_LPTR: begin
                if (xfer) begin
                    st_nxt = S_LTAIL;
                end
            end
            S_LTAIL: begin
                if (xfer) begin
                    st_nxt = hold_r ? S_HOLD : cont_st;
                end
            end
            S_HOLD: begin
                if (~hpst_r[`BCX_HP_MERR]) begin
                    st_nxt = cont_st;
                end
            end
            S_DELAY: begin
                if (ticks_r == 8'h00) begin
                    st_nxt = err_blk_r ? S_WCTRL : S_RTAIL;
                end
            end
            S_WCTRL: begin
                if (xfer) begin
                    st_nxt = S_RTAIL;
                end
            end
            S_RTAIL: begin
                if (xfer) begin
                    st_nxt = S_DHOLD;
                end
            end
            S_DHOLD: begin
                st_nxt = S_FCTRL;
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    //--------------------------------------------------------------
    // Memory port
    //--------------------------------------------------------------
    // The request stays up across a whole sequence so that it runs as one
    // burst; only the idle, running, hold and delay states let go of the bus.
    always @* begin
        O_DMA_REQ   = 1'b1;
        O_MEM_RD    = 1'b0;
        O_MEM_WR    = 1'b0;
        O_MEM_ADDR  = `BCX_RST_W16;
        O_MEM_WDATA = `BCX_RST_W16;
        case (st_r)
            S_FCTRL: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = blk_r + `BCX_CB_CTRL;
            end
            S_FCMD: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = blk_r + `BCX_CB_CMD1;
            end
            S_FDPTR: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = blk_r + `BCX_CB_DPTR;
            end
            S_FDATA: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = dptr_r;
            end
            S_RUN: begin
                O_DMA_REQ  = fetch;
                O_MEM_RD   = fetch & I_DMA_GNT;
                O_MEM_ADDR = dptr_r + idx_r;
            end
            S_WSTAT: begin
                O_MEM_WR    = I_DMA_GNT;
                O_MEM_ADDR  = blk_r + `BCX_CB_STAT1;
                O_MEM_WDATA = stat_r;
            end
            S_LISW: begin
                O_MEM_WR    = I_DMA_GNT;
                O_MEM_ADDR  = log_r + `BCX_LG_ISW;
                O_MEM_WDATA = isw_r | (16'h0001 << `BCX_IS_ACC);
            end
            S_LPTR: begin
                O_MEM_WR    = I_DMA_GNT;
                O_MEM_ADDR  = log_r + `BCX_LG_PTR;
                O_MEM_WDATA = blk_r;
            end
            S_LTAIL: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = log_r + `BCX_LG_TAIL;
            end
            S_WCTRL: begin
                O_MEM_WR    = I_DMA_GNT;
                O_MEM_ADDR  = blk_r + `BCX_CB_CTRL;
                O_MEM_WDATA = ctrl_r;
            end
            S_RTAIL: begin
                O_MEM_RD   = I_DMA_GNT;
                O_MEM_ADDR = blk_r + `BCX_CB_TAIL;
            end
            S_DHOLD: begin
                O_DMA_REQ = 1'b1;
            end
            default: begin
                O_DMA_REQ = 1'b0;
            end
        endcase
    end

    //--------------------------------------------------------------
    // Interrupt causes
    //--------------------------------------------------------------
    always @* begin
        hpst_set = 3'b000;
        if ((st_r == S_RUN) & I_MSG_DONE & err_now) begin
            hpst_set[`BCX_HP_MERR] = hpen_r[`BCX_HP_MERR];
        end
        if (((st_r == S_LTAIL) | (st_r == S_WSTAT) | (st_r == S_HOLD)
             | (st_r == S_FDPTR)) & (st_nxt == S_IDLE)) begin
            hpst_set[`BCX_HP_LAST] = hpen_r[`BCX_HP_LAST];
        end
        if ((st_r == S_LTAIL) & xfer) begin
            hpst_set[`BCX_HP_STD] = hpen_r[`BCX_HP_STD];
        end
        // A cause raised in the same cycle as its clear survives.
        hpst_nxt = hpst_r;
        if (I_REG_WR & (I_REG_ADDR == `BCX_REG_HPST)) begin
            hpst_nxt = hpst_r & ~I_REG_WDATA[2:0];
        end
        hpst_nxt = hpst_nxt | hpst_set;
    end

    always @* begin
        case (I_REG_ADDR)
            `BCX_REG_CTRL:  rdat_nxt = {O_BUSY, st_r == S_HOLD, 10'h000, gcfg_r, 1'b0};
            `BCX_REG_LOG:   rdat_nxt = log_r;
            `BCX_REG_HPEN:  rdat_nxt = {13'h0000, hpen_r};
            `BCX_REG_HPST:  rdat_nxt = {13'h0000, hpst_r};
            `BCX_REG_STDEN: rdat_nxt = {12'h000, stden_r};
            `BCX_REG_POLL:  rdat_nxt = poll_r;
            `BCX_REG_CUR:   rdat_nxt = cur_r;
            default:        rdat_nxt = `BCX_RST_W16;
        endcase
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always @(posedge I_CLK) begin
        if (I_RESET) begin
            st_r                   <= S_IDLE;
            log_r                  <= `BCX_RST_W16;
            cur_r                  <= `BCX_RST_W16;
            blk_r                  <= `BCX_RST_W16;
            ctrl_r                 <= `BCX_RST_W16;
            dptr_r                 <= `BCX_RST_W16;
            idx_r                  <= `BCX_RST_W16;
            stat_r                 <= `BCX_RST_W16;
            isw_r                  <= `BCX_RST_W16;
            poll_r                 <= `BCX_RST_W16;
            hpen_r                 <= 3'b000;
            hpst_r                 <= 3'b000;
            stden_r                <= 4'h0;
            gcfg_r                 <= 3'b000;
            rcnt_r                 <= 2'b00;
            first_r                <= 1'b0;
            err_blk_r              <= 1'b0;
            retry_r                <= 1'b0;
            hold_r                 <= 1'b0;
            skip_r                 <= 1'b0;
            need_tx_r              <= 1'b0;
            presc_r                <= 10'h000;
            ticks_r                <= 8'h00;
            O_REG_RDATA            <= `BCX_RST_W16;
            O_MSG_START            <= 1'b0;
            O_MSG_CMD              <= `BCX_RST_W16;
            O_MSG_ALT_BUS          <= 1'b0;
            O_TX_DATA              <= `BCX_RST_W16;
            O_TX_VALID             <= 1'b0;
            O_HIGH_PRIORITY_IRQ_N  <= 1'b1;
            O_STANDARD_IRQ_LEVEL_N <= 1'b1;
            O_STANDARD_IRQ_PULSE_N <= 1'b1;
        end else begin
            st_r        <= st_nxt;
            hpst_r      <= hpst_nxt;
            O_REG_RDATA <= I_REG_RD ? rdat_nxt : `BCX_RST_W16;
            O_MSG_START <= 1'b0;
            O_HIGH_PRIORITY_IRQ_N  <= ~(|hpst_nxt[1:0]);
            O_STANDARD_IRQ_LEVEL_N <= ~hpst_nxt[`BCX_HP_STD];
            O_STANDARD_IRQ_PULSE_N <= ~((st_r == S_LTAIL) & xfer);
            if (I_REG_WR) begin
                case (I_REG_ADDR)
                    `BCX_REG_CTRL:  gcfg_r  <= I_REG_WDATA[3:1];
                    `BCX_REG_LOG:   log_r   <= I_REG_WDATA;
                    `BCX_REG_HPEN:  hpen_r  <= I_REG_WDATA[2:0];
                    `BCX_REG_STDEN: stden_r <= I_REG_WDATA[3:0];
                    `BCX_REG_POLL:  poll_r  <= I_REG_WDATA;
                    `BCX_REG_CUR:   cur_r   <= I_REG_WDATA;
                    default:        ;
                endcase
            end
            if (start) begin
                blk_r         <= cur_r;
                first_r       <= 1'b1;
                err_blk_r     <= 1'b0;
                retry_r       <= 1'b0;
                O_MSG_ALT_BUS <= 1'b0;
                // The start write itself carries the retry count of the first block.
                rcnt_r        <= I_REG_WDATA[3:2];
            end
            // Delay timer: whole steps, held across retries of the block.
            if (ticks_r != 8'h00) begin
                if (presc_r == STEP_CYC - 10'h001) begin
                    presc_r <= 10'h000;
                    ticks_r <= ticks_r - 8'h01;
                end else begin
                    presc_r <= presc_r + 10'h001;
                end
            end
            case (st_r)
                S_FCTRL: begin
                    if (xfer) begin
                        // A retry re-read must not lose the error mark.
                        ctrl_r <= I_MEM_RDATA | {err_blk_r, 15'h0000};
                    end
                end
                S_FCMD: begin
                    if (xfer) begin
                        O_MSG_CMD <= I_MEM_RDATA;
                    end
                end
                S_FDPTR: begin
                    if (xfer) begin
                        dptr_r    <= I_MEM_RDATA;
                        idx_r     <= `BCX_RST_W16;
                        skip_r    <= ctrl_r[`BCX_CW_SKIP];
                        retry_r   <= 1'b0;
                        hold_r    <= 1'b0;
                        isw_r     <= {15'h0000, ctrl_r[`BCX_CW_IC] & stden_r[0]};
                        need_tx_r <= ~O_MSG_CMD[`BCX_CMD_TR] & ~ctrl_r[`BCX_CW_RTRT];
                        if (first_r) begin
                            first_r <= 1'b0;
                            presc_r <= 10'h000;
                            ticks_r <= ctrl_r[7:0];
                        end
                        if (~ctrl_r[`BCX_CW_SKIP] & (O_MSG_CMD[`BCX_CMD_TR] | ctrl_r[`BCX_CW_RTRT])) begin
                            O_MSG_START <= 1'b1;
                        end
                    end
                end
                S_FDATA: begin
                    if (xfer) begin
                        O_TX_DATA   <= I_MEM_RDATA;
                        O_TX_VALID  <= 1'b1;
                        idx_r       <= 16'h0001;
                        O_MSG_START <= 1'b1;
                    end
                end
                S_RUN: begin
                    if (I_TX_TAKE & O_TX_VALID) begin
                        O_TX_VALID <= 1'b0;
                    end else if (fetch & xfer) begin
                        O_TX_DATA  <= I_MEM_RDATA;
                        O_TX_VALID <= 1'b1;
                        idx_r      <= idx_r + 16'h0001;
                    end
                    if (I_MSG_DONE) begin
                        O_TX_VALID <= 1'b0;
                        need_tx_r  <= 1'b0;
                        stat_r     <= I_MSG_STATUS;
                        isw_r      <= raw_ev & {12'h000, stden_r};
                        hold_r     <= err_now & hpen_r[`BCX_HP_MERR];
                        retry_r    <= rtry_ok & (rcnt_r != 2'b00);
                        if (err_now) begin
                            err_blk_r <= 1'b1;
                            ctrl_r[`BCX_CW_MERR] <= 1'b1;
                        end
                        if (rtry_ok & (rcnt_r != 2'b00)) begin
                            rcnt_r        <= rcnt_r - 2'b01;
                            O_MSG_ALT_BUS <= ~O_MSG_ALT_BUS;
                        end
                    end
                end
                S_LTAIL: begin
                    if (xfer) begin
                        log_r <= I_MEM_RDATA;
                    end
                end
                S_RTAIL: begin
                    if (xfer) begin
                        cur_r <= I_MEM_RDATA;
                        blk_r <= I_MEM_RDATA;
                    end
                end
                S_DHOLD: begin
                    first_r       <= 1'b1;
                    err_blk_r     <= 1'b0;
                    O_MSG_ALT_BUS <= 1'b0;
                    rcnt_r        <= gcfg_r[2:1];
                end
                default: ;
            endcase
        end
    end

endmodule // bcx_exception_log

`default_nettype wire

// [tb/bcx_exception_log_sva.sv]
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module bcx_chk (
    input wire logic        I_CLK,
    input wire logic        I_RESET,
    input wire logic [3:0]  I_REG_ADDR,
    input wire logic        I_REG_WR,
    input wire logic        I_DMA_GNT,
    input wire logic        I_MEM_ACK,
    input wire logic        I_MSG_DONE,
    input wire logic        O_DMA_REQ,
    input wire logic        O_MEM_RD,
    input wire logic        O_MEM_WR,
    input wire logic [15:0] O_MEM_ADDR,
    input wire logic [15:0] O_MEM_WDATA,
    input wire logic        O_MSG_START,
    input wire logic        O_HIGH_PRIORITY_IRQ_N,
    input wire logic        O_STANDARD_IRQ_LEVEL_N,
    input wire logic        O_STANDARD_IRQ_PULSE_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    AST_GRANT: assert property ((O_MEM_RD || O_MEM_WR) |-> I_DMA_GNT && O_DMA_REQ)
        else $error("strobe without grant");
    AST_EXCL: assert property (!(O_MEM_RD && O_MEM_WR))
        else $error("read and write together");
    AST_WHOLD: assert property (O_MEM_WR && !I_MEM_ACK ##1 I_DMA_GNT |->
        O_MEM_WR && $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA)) else $error("write dropped");
    AST_PULSE1: assert property ($fell(O_STANDARD_IRQ_PULSE_N) |=> O_STANDARD_IRQ_PULSE_N)
        else $error("pulse too long");
    AST_PULSE_TAIL: assert property ($fell(O_STANDARD_IRQ_PULSE_N) |->
        $past(O_MEM_RD) && $past(I_MEM_ACK)) else $error("pulse not after tail read");
    AST_LEVEL: assert property (!O_STANDARD_IRQ_LEVEL_N && !(I_REG_WR && I_REG_ADDR == 4'h8)
        |=> !O_STANDARD_IRQ_LEVEL_N) else $error("level dropped alone");
    AST_HPSTAY: assert property (!O_HIGH_PRIORITY_IRQ_N && !(I_REG_WR && I_REG_ADDR == 4'h8)
        |=> !O_HIGH_PRIORITY_IRQ_N) else $error("high priority dropped alone");
    AST_HOLD: assert property (!O_HIGH_PRIORITY_IRQ_N && !I_REG_WR |=> !O_MSG_START)
        else $error("message started while held");
    AST_DONE_REQ: assert property (I_MSG_DONE |=> O_DMA_REQ)
        else $error("status not stored");
endmodule // bcx_chk
bind bcx_exception_log bcx_chk bcx_chk_i (.I_CLK, .I_RESET, .I_REG_ADDR, .I_REG_WR, .I_DMA_GNT,
    .I_MEM_ACK, .I_MSG_DONE, .O_DMA_REQ, .O_MEM_RD, .O_MEM_WR, .O_MEM_ADDR, .O_MEM_WDATA,
    .O_MSG_START, .O_HIGH_PRIORITY_IRQ_N, .O_STANDARD_IRQ_LEVEL_N, .O_STANDARD_IRQ_PULSE_N);
`default_nettype wire

// [tb/bcx_mem_model.sv]
`default_nettype none
// ----------------------------------------
// Shared RAM behind the DMA port
// ----------------------------------------
module bcx_mem_model (
    input wire logic        i_clk,
    input wire logic        i_slow,
    input wire logic        i_req,
    input wire logic        i_rd,
    input wire logic        i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic            o_gnt,
    output logic            o_ack,
    output logic [15:0]     o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    logic [1:0]  cnt = 2'h0;
    // Host-linked command blocks and log tail pointers live here.
    always @(posedge i_clk) begin
        cnt <= cnt + 2'h1;
        if (o_ack && i_wr) begin
            mem[i_addr[7:0]] <= i_wdata;
        end
    end
    assign o_gnt = i_req;
    assign o_ack = (i_rd || i_wr) && (!i_slow || cnt == 2'h3);
    // Data off the acknowledged cycle is inverted so stale reads cannot pass.
    assign o_rdata = o_ack ? mem[i_addr[7:0]] : ~mem[i_addr[7:0]];
endmodule // bcx_mem_model
`default_nettype wire

// [tb/bcx_exception_log_tb.sv]
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module bcx_exception_log_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_CLK = 0, I_RESET = 1, I_REG_WR = 0, I_REG_RD = 0, I_MSG_DONE = 0, I_MSG_ERROR = 0;
    logic I_TX_TAKE = 0, slow = 0, err_once = 0;
    logic [3:0] I_REG_ADDR = 4'h0;
    logic [15:0] I_REG_WDATA = 16'h0, I_MSG_STATUS = 16'h0, sts = 16'h0;
    wire logic [15:0] O_REG_RDATA, O_MEM_ADDR, O_MEM_WDATA, I_MEM_RDATA, O_MSG_CMD, O_TX_DATA;
    wire logic O_DMA_REQ, I_DMA_GNT, O_MEM_RD, O_MEM_WR, I_MEM_ACK, O_MSG_START, O_MSG_ALT_BUS;
    wire logic O_TX_VALID, O_HIGH_PRIORITY_IRQ_N, O_STANDARD_IRQ_LEVEL_N, O_STANDARD_IRQ_PULSE_N, O_BUSY;
    int n_errors = 0, num_checks = 0, n_pulse = 0, n_start = 0, dly = 0, k;
    time t_st [0:7];
    logic alt [0:7];
    logic [15:0] txw [0:1];
    int n_tx = 0;
    bcx_exception_log bcx_exception_log_i (.I_CLK, .I_RESET, .I_REG_ADDR, .I_REG_WDATA, .I_REG_WR,
        .I_REG_RD, .O_REG_RDATA, .O_DMA_REQ, .I_DMA_GNT, .O_MEM_ADDR, .O_MEM_WDATA, .O_MEM_RD,
        .O_MEM_WR, .I_MEM_ACK, .I_MEM_RDATA, .O_MSG_START, .O_MSG_CMD, .O_MSG_ALT_BUS, .I_MSG_DONE,
        .I_MSG_STATUS, .I_MSG_ERROR, .O_TX_DATA, .O_TX_VALID, .I_TX_TAKE, .O_HIGH_PRIORITY_IRQ_N,
        .O_STANDARD_IRQ_LEVEL_N, .O_STANDARD_IRQ_PULSE_N, .O_BUSY);
    bcx_mem_model mem_i (.i_clk(I_CLK), .i_slow(slow), .i_req(O_DMA_REQ), .i_rd(O_MEM_RD),
        .i_wr(O_MEM_WR), .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_gnt(I_DMA_GNT),
        .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));
    initial forever #10 I_CLK = ~I_CLK;
    // ----------------------------------------
    // Serial engine stand-in
    // ----------------------------------------
    always @(posedge I_CLK) begin
        I_TX_TAKE <= O_TX_VALID && !I_TX_TAKE;
        I_MSG_DONE <= (dly == 1) && !O_MSG_START;
        I_MSG_STATUS <= sts;
        I_MSG_ERROR <= err_once;
        if (I_MSG_DONE) err_once <= 0;
        if (!O_STANDARD_IRQ_PULSE_N) n_pulse <= n_pulse + 1;
        if (I_TX_TAKE && O_TX_VALID && n_tx < 2) begin
            txw[n_tx] <= O_TX_DATA;
            n_tx <= n_tx + 1;
        end
        if (O_MSG_START) begin
            t_st[n_start] <= $time;
            alt[n_start] <= O_MSG_ALT_BUS;
            n_start <= n_start + 1;
            dly <= 6;
        end else if (dly != 0) dly <= dly - 1;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_REG_WR <= 1; I_REG_ADDR <= a; I_REG_WDATA <= d;
        @(posedge I_CLK);
        I_REG_WR <= 0;
        @(negedge I_CLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge I_CLK);
        I_REG_RD <= 1; I_REG_ADDR <= a;
        @(posedge I_CLK);
        I_REG_RD <= 0;
        @(negedge I_CLK);
        `CHK(O_REG_RDATA, e)
    endtask
    task automatic idle;
        for (k = 0; k < 5000 && O_BUSY !== 1'b0; k++) @(negedge I_CLK);
        `CHK(O_BUSY, 1'b0)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(30000 * 20);
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge I_CLK);
        I_RESET <= 0;
        rd(4'h8, 16'h0000);
        rd(4'hf, 16'h0000);
        `CHK({O_HIGH_PRIORITY_IRQ_N, O_STANDARD_IRQ_LEVEL_N, O_STANDARD_IRQ_PULSE_N}, 3'h7)
        $display("test reset done");
        mem_i.mem[8'h11] = 16'h2000; mem_i.mem[8'h12] = 16'h0400; mem_i.mem[8'h17] = 16'h0020;
        mem_i.mem[8'h21] = 16'h1400; mem_i.mem[8'h22] = 16'h0000; mem_i.mem[8'h42] = 16'h0050;
        mem_i.mem[8'h24] = 16'h0080; mem_i.mem[8'h80] = 16'habcd; mem_i.mem[8'h81] = 16'h1234;
        mem_i.mem[8'h52] = 16'h0060; mem_i.mem[8'h62] = 16'h0070; sts = 16'h0004;
        wr(4'h6, 16'h0040); wr(4'h7, 16'h0005); wr(4'h9, 16'h0009); wr(4'ha, 16'h0004);
        wr(4'hb, 16'h0010); wr(4'h0, 16'h0001);
        idle;
        `CHK(mem_i.mem[8'h40], 16'h8001)
        `CHK(mem_i.mem[8'h41], 16'h0010)
        `CHK(mem_i.mem[8'h50], 16'h8008)
        `CHK(mem_i.mem[8'h25], 16'h0004)
        `CHK(n_pulse, 2)
        `CHK({txw[0], txw[1]}, 32'habcd1234)
        `CHK({O_HIGH_PRIORITY_IRQ_N, O_STANDARD_IRQ_LEVEL_N}, 2'h0)
        rd(4'h6, 16'h0060);
        rd(4'h8, 16'h0005);
        rd(4'hb, 16'h0020);
        wr(4'h8, 16'h0005);
        `CHK({O_HIGH_PRIORITY_IRQ_N, O_STANDARD_IRQ_LEVEL_N}, 2'h3)
        $display("test chain done");
        mem_i.mem[8'h31] = 16'h2801; mem_i.mem[8'h32] = 16'h0400; mem_i.mem[8'h37] = 16'h0020;
        mem_i.mem[8'h21] = 16'h0400; sts = 16'h0000; err_once = 1; slow = 1;
        wr(4'h7, 16'h0007); wr(4'h9, 16'h0002); wr(4'hb, 16'h0030); wr(4'h0, 16'h0007);
        for (k = 0; k < 3000 && O_HIGH_PRIORITY_IRQ_N !== 1'b0; k++) @(negedge I_CLK);
        repeat (30) @(negedge I_CLK);
        `CHK({O_BUSY, n_start == 3}, 2'h3)
        `CHK(mem_i.mem[8'h60], 16'h8002)
        rd(4'h8, 16'h0006);
        wr(4'h8, 16'h0002);
        idle;
        `CHK(n_start, 5)
        `CHK({alt[2], alt[3]}, 2'h1)
        `CHK(mem_i.mem[8'h31], 16'ha801)
        `CHK(t_st[4] - t_st[2] >= 800 * 20, 1'b1)
        `CHK(O_STANDARD_IRQ_LEVEL_N, 1'b0)
        rd(4'hb, 16'h0020);
        rd(4'h6, 16'h0070);
        rd(4'h8, 16'h0005);
        $display("test error hold done");
        give_verdict;
    end
endmodule // bcx_exception_log_tb
`default_nettype wire
